// ---- core_irq_model.sv ----
`timescale 1ns/1ps
module core_irq_model (
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  input  wire logic irq_in,
  output int        irq_count_out
);
  logic irq_q_r;
  // The core has one shared vector, so it can only count handler entries
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_q_r       <= 1'b0;
      irq_count_out <= 0;
    end else begin
      irq_q_r <= irq_in;
      if (irq_in && !irq_q_r) begin
        irq_count_out <= irq_count_out + 1;
      end
    end
  end
endmodule

// ---- power_supply_event_interrupts.sv ----
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module power_supply_event_interrupts #(
  parameter int MEAS_PERIOD_CYC = psu_irq_pkg::MEAS_PERIOD_DEF,
  parameter int SAG_CNT_W       = 8
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   reset_in,
  input  wire logic [7:0]             addr_in,
  input  wire logic [7:0]             wr_data_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [7:0]             rd_data_out,
  input  wire logic                   supply_on_battery_in,
  input  wire logic                   dc_input_low_in,
  input  wire logic                   line_below_in,
  input  wire logic                   line_cycle_in,
  input  wire logic [SAG_CNT_W-1:0]   sag_cycle_count_in,
  input  wire logic [7:0]             vsw_result_in,
  input  wire logic                   vsw_valid_in,
  input  wire logic [7:0]             battery_result_in,
  input  wire logic                   battery_valid_in,
  output logic                        measure_start_out,
  output logic                        dc_switch_req_out,
  output logic                        power_monitor_interrupt_out
);
  localparam int NS = psu_irq_pkg::NUM_SOURCES;
  localparam int PER_W = $clog2(MEAS_PERIOD_CYC + 1);
  localparam logic [PER_W-1:0] PER_LAST = PER_W'(MEAS_PERIOD_CYC - 1);

  logic [NS-1:0]    flags_r;
  logic [NS-1:0]    flags_nxt;
  logic [NS-1:0]    set_mask;
  logic [NS-1:0]    clr_mask;
  logic [NS-1:0]    irq_enable_r;
  logic [7:0]       global_reg_r;
  logic [7:0]       supply_delta_r;
  logic [7:0]       peripheral_config_cfg_r;
  logic [7:0]       switch_cfg_r;
  logic [7:0]       bat_thresh_r;
  logic [7:0]       bat_result_r;
  logic [7:0]       last_vsw_r;
  logic             meas_pending_r;
  logic             on_battery_r;
  logic             primed_r;
  logic [PER_W-1:0] period_cnt_r;
  logic [11:0]      dc_cnt_r;
  logic [11:0]      dc_limit;
  logic [8:0]       vsw_diff;
  logic [7:0]       vsw_mag;
  logic             sag_event;
  logic             switchover_ev;
  logic             restore_ev;
  logic             delta_ev;
  logic             battery_ev;
  logic             global_en;
  logic             launch;
  logic             wr_flags;

  assign global_en = global_reg_r[psu_irq_pkg::GLOBAL_EN_BIT];
  assign wr_flags  = wr_in && addr_in == psu_irq_pkg::IRQ_FLAGS_ADDR;

  sag_cycle_detector #(
    .CNT_W (SAG_CNT_W)
  ) u_sag (
    .sys_clk_in         (sys_clk_in),
    .reset_in           (reset_in),
    .line_below_in      (line_below_in),
    .line_cycle_in      (line_cycle_in),
    .sag_cycle_count_in (sag_cycle_count_in),
    .sag_event_out      (sag_event)
  );

  // Supply source tracking; first edge after reset only samples, so a part
  // that wakes on battery does not report a spurious switchover
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      on_battery_r <= 1'b0;
      primed_r     <= 1'b0;
    end else begin
      on_battery_r <= supply_on_battery_in;
      primed_r     <= 1'b1;
    end
  end

  assign switchover_ev = primed_r && supply_on_battery_in && !on_battery_r;
  assign restore_ev    = primed_r && !supply_on_battery_in && on_battery_r;

  // Supply magnitude change against the previous result
  always_comb begin
    vsw_diff = {1'b0, vsw_result_in} - {1'b0, last_vsw_r};
    if (vsw_diff[8]) begin
      vsw_mag = 8'(~vsw_diff[7:0] + 8'h01);
    end else begin
      vsw_mag = vsw_diff[7:0];
    end
  end

  assign delta_ev   = vsw_valid_in && vsw_mag > supply_delta_r;
  // Level is only known from a result, so every new result sets the flag
  assign battery_ev = battery_valid_in;

  always_comb begin
    set_mask = '0;
    set_mask[psu_irq_pkg::SWITCHOVER_BIT]   = switchover_ev;
    set_mask[psu_irq_pkg::RESTORE_BIT]      = restore_ev;
    set_mask[psu_irq_pkg::SUPPLY_DELTA_BIT] = delta_ev;
    set_mask[psu_irq_pkg::BATTERY_BIT]      = battery_ev;
    set_mask[psu_irq_pkg::DC_INPUT_BIT]     = dc_input_low_in;
    set_mask[psu_irq_pkg::SAG_BIT]          = sag_event;
    clr_mask = wr_flags ? ~wr_data_in[NS-1:0] : '0;
    // A new event beats a clear in the same cycle
    flags_nxt = (flags_r & ~clr_mask) | set_mask;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Software-written configuration
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_enable_r   <= '0;
      global_reg_r   <= psu_irq_pkg::ZERO_BYTE;
      supply_delta_r <= psu_irq_pkg::SUPPLY_DELTA_RST;
      peripheral_config_cfg_r   <= psu_irq_pkg::ZERO_BYTE;
      switch_cfg_r   <= psu_irq_pkg::ZERO_BYTE;
      bat_thresh_r   <= psu_irq_pkg::BAT_THRESH_RST;
    end else if (wr_in) begin
      unique case (addr_in)
        psu_irq_pkg::IRQ_ENABLE_ADDR:   irq_enable_r   <= wr_data_in[NS-1:0];
        psu_irq_pkg::IRQ_GLOBAL_ADDR:   global_reg_r   <= wr_data_in;
        psu_irq_pkg::SUPPLY_DELTA_ADDR: supply_delta_r <= wr_data_in;
        psu_irq_pkg::PERIPHERAL_CONFIG_CFG_ADDR:   peripheral_config_cfg_r   <= wr_data_in;
        psu_irq_pkg::SWITCH_CFG_ADDR:   switch_cfg_r   <= wr_data_in;
        psu_irq_pkg::BAT_THRESH_ADDR:   bat_thresh_r   <= wr_data_in;
        default: begin
        end
      endcase
    end
  end

  // Measurement results kept for comparison and readback
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      last_vsw_r   <= psu_irq_pkg::ZERO_BYTE;
      bat_result_r <= psu_irq_pkg::ZERO_BYTE;
    end else begin
      if (vsw_valid_in) begin
        last_vsw_r <= vsw_result_in;
      end
      if (battery_valid_in) begin
        bat_result_r <= battery_result_in;
      end
    end
  end

  // Background measurement timer plus on-demand launch
  assign launch = (period_cnt_r == PER_LAST)
                  || (wr_in && addr_in == psu_irq_pkg::MEAS_START_ADDR);

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      period_cnt_r      <= '0;
      measure_start_out <= 1'b0;
    end else begin
      measure_start_out <= launch;
      if (launch) begin
        period_cnt_r <= '0;
      end else begin
        period_cnt_r <= period_cnt_r + 1'b1;
      end
    end
  end

  // Pending stays high until the converter answers; a new launch wins
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      meas_pending_r <= 1'b0;
    end else if (launch) begin
      meas_pending_r <= 1'b1;
    end else if (vsw_valid_in) begin
      meas_pending_r <= 1'b0;
    end
  end

  // DC-input switchover delay; the count restarts if the input recovers
  always_comb begin
    unique case (switch_cfg_r[1:0])
      2'h0: dc_limit = psu_irq_pkg::DC_TMO0_CYC;
      2'h1: dc_limit = psu_irq_pkg::DC_TMO1_CYC;
      2'h2: dc_limit = psu_irq_pkg::DC_TMO2_CYC;
      2'h3: dc_limit = psu_irq_pkg::DC_TMO3_CYC;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dc_cnt_r          <= '0;
      dc_switch_req_out <= 1'b0;
    end else if (!dc_input_low_in || !switch_cfg_r[psu_irq_pkg::DC_SWITCH_EN_BIT]) begin
      dc_cnt_r          <= '0;
      dc_switch_req_out <= 1'b0;
    end else if (dc_cnt_r < dc_limit) begin
      dc_cnt_r <= dc_cnt_r + 1'b1;
    end else begin
      dc_switch_req_out <= 1'b1;
    end
  end

  // Single shared request, registered
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      power_monitor_interrupt_out <= 1'b0;
    end else begin
      power_monitor_interrupt_out <= global_en && |(flags_r & irq_enable_r);
    end
  end

  // Read port, data in the cycle after the strobe only
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= psu_irq_pkg::ZERO_BYTE;
    end else if (!rd_in) begin
      rd_data_out <= psu_irq_pkg::ZERO_BYTE;
    end else begin
      unique case (addr_in)
        psu_irq_pkg::MEAS_START_ADDR:   rd_data_out <= {7'h00, meas_pending_r};
        psu_irq_pkg::BAT_RESULT_ADDR:   rd_data_out <= bat_result_r;
        psu_irq_pkg::IRQ_ENABLE_ADDR:   rd_data_out <= {2'h0, irq_enable_r};
        psu_irq_pkg::IRQ_GLOBAL_ADDR:   rd_data_out <= global_reg_r;
        psu_irq_pkg::SUPPLY_DELTA_ADDR: rd_data_out <= supply_delta_r;
        psu_irq_pkg::SWITCH_CFG_ADDR:   rd_data_out <= switch_cfg_r;
        psu_irq_pkg::BAT_THRESH_ADDR:   rd_data_out <= bat_thresh_r;
        psu_irq_pkg::IRQ_FLAGS_ADDR:    rd_data_out <= {2'h0, flags_r};
        psu_irq_pkg::PERIPHERAL_CONFIG_CFG_ADDR: begin
          rd_data_out <= peripheral_config_cfg_r;
          rd_data_out[psu_irq_pkg::SOURCE_MAIN_BIT] <= !on_battery_r;
        end
        default: rd_data_out <= psu_irq_pkg::ZERO_BYTE;
      endcase
    end
  end

  switchover_flag_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    switchover_ev |=> flags_r[psu_irq_pkg::SWITCHOVER_BIT])
    else $error("switchover flag not set");

  restore_flag_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    restore_ev |=> flags_r[psu_irq_pkg::RESTORE_BIT])
    else $error("restore flag not set");

  flag_latched_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $fell(flags_r[psu_irq_pkg::SWITCHOVER_BIT]) |->
      $past(wr_flags) && !$past(wr_data_in[psu_irq_pkg::SWITCHOVER_BIT]))
    else $error("switchover flag dropped without zero write");

  set_beats_clear_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (wr_flags && restore_ev) |=> flags_r[psu_irq_pkg::RESTORE_BIT])
    else $error("restore event lost to clear");

  source_read_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (rd_in && addr_in == psu_irq_pkg::PERIPHERAL_CONFIG_CFG_ADDR) |=>
      rd_data_out[psu_irq_pkg::SOURCE_MAIN_BIT] == !$past(on_battery_r))
    else $error("supply source bit wrong");

  delta_flag_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (vsw_valid_in && vsw_mag > supply_delta_r) |=>
      flags_r[psu_irq_pkg::SUPPLY_DELTA_BIT])
    else $error("supply delta flag not set");

  meas_launch_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (wr_in && addr_in == psu_irq_pkg::MEAS_START_ADDR) |=> measure_start_out && meas_pending_r)
    else $error("on-demand measurement not launched");

  meas_periodic_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(measure_start_out) |-> ##[1:1000] measure_start_out || MEAS_PERIOD_CYC > 1000)
    else $error("background measurement stalled");

  battery_flag_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    battery_valid_in |=> flags_r[psu_irq_pkg::BATTERY_BIT]
      && bat_result_r == $past(battery_result_in))
    else $error("battery flag or result not updated");

  dc_flag_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    dc_input_low_in |=> flags_r[psu_irq_pkg::DC_INPUT_BIT])
    else $error("dc input low flag not set");

  sag_flag_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    sag_event |=> flags_r[psu_irq_pkg::SAG_BIT])
    else $error("sag flag not set");

  dc_timeout_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(dc_switch_req_out) |-> $past(dc_cnt_r) == $past(dc_limit)
      && $past(dc_input_low_in))
    else $error("dc switchover request before timeout");

  irq_equation_a: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    power_monitor_interrupt_out == $past(global_en && |(flags_r & irq_enable_r)))
    else $error("interrupt does not follow flags and enables");

  irq_gated_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !global_en ##1 !global_en |-> !power_monitor_interrupt_out)
    else $error("interrupt passed without global enable");

  flags_sticky_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !$past(wr_flags) |-> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag dropped without a flag write");

  clear_zero_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    wr_flags |=> (flags_r & ~($past(wr_data_in[NS-1:0]) | $past(set_mask))) == '0)
    else $error("flag survived a zero write");

  irq_off_reset_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $fell(reset_in) |-> !power_monitor_interrupt_out && !global_en)
    else $error("interrupt live after reset");

  source_track_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    primed_r |-> on_battery_r == $past(supply_on_battery_in))
    else $error("supply source not tracked");

  dc_req_off_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (!dc_input_low_in || !switch_cfg_r[psu_irq_pkg::DC_SWITCH_EN_BIT]) |=> !dc_switch_req_out)
    else $error("dc switchover request without low input");

  sag_once_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    sag_event |=> !sag_event)
    else $error("sag reported twice in one episode");

  battery_rise_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(flags_r[psu_irq_pkg::BATTERY_BIT]) |-> $past(battery_valid_in))
    else $error("battery flag set without a result");

  delta_rise_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(flags_r[psu_irq_pkg::SUPPLY_DELTA_BIT]) |-> $past(vsw_valid_in))
    else $error("supply delta flag set without a result");

  switch_rise_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(flags_r[psu_irq_pkg::SWITCHOVER_BIT]) |->
      $past(supply_on_battery_in) && !$past(on_battery_r))
    else $error("switchover flag set without a switchover");

  irq_masked_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (flags_r & irq_enable_r) == '0 |=> !power_monitor_interrupt_out)
    else $error("interrupt raised by a masked flag");
endmodule

// ---- psu_irq_pkg.sv ----
// Behaviour
// - Supply moving from main to battery raises the interrupt when its enable is set.
// - Supply returning from battery to main raises the interrupt when its enable is set.
// - Switchover and restore flags set on their events regardless of enable bits.
// - Switchover and restore flags stay latched until software writes zero to each.
// - Peripheral config bit 6 reads one on main supply, zero on battery.
// - Switched-supply change above programmed delta threshold is a power-monitor event.
// - Supply-delta event interrupts only when its enable bit is set.
// - Supply measurements run periodically; writing measurement start launches one on demand.
// - Supply-delta indication is evaluated once a new supply measurement result is ready.
// - Battery flag sets on a new battery result or level below battery threshold.
// - Battery event interrupts only when its enable bit is set.
// - DC-input low flag sets while the comparator reports below 1.2 V.
// - DC-input low event interrupts only when its enable bit is set.
// - Sag flag sets when line stays below threshold for programmed line cycles.
// - Sag event interrupts only when its enable bit is set.
// - Two-bit timeout field selects delay from DC-input low to switchover request.
// - Interrupt off after reset; reaches processor only with global enable set.
// - All power events share one interrupt output.
package psu_irq_pkg;
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 8;
  localparam logic [7:0]  MEAS_START_ADDR  = 8'hD8;
  localparam logic [7:0]  BAT_RESULT_ADDR  = 8'hDF;
  localparam logic [7:0]  IRQ_ENABLE_ADDR  = 8'hEC;
  localparam logic [7:0]  SUPPLY_DELTA_ADDR = 8'hF3;
  localparam logic [7:0]  PERIPHERAL_CONFIG_CFG_ADDR  = 8'hF4;
  localparam logic [7:0]  SWITCH_CFG_ADDR  = 8'hF5;
  localparam logic [7:0]  IRQ_FLAGS_ADDR   = 8'hF8;
  localparam logic [7:0]  BAT_THRESH_ADDR  = 8'hFA;
  localparam logic [7:0]  IRQ_GLOBAL_ADDR  = 8'hA9;
  // Flag and enable bit positions, same layout in both registers
  localparam int          SUPPLY_DELTA_BIT = 0;
  localparam int          BATTERY_BIT      = 1;
  localparam int          SWITCHOVER_BIT   = 2;
  localparam int          RESTORE_BIT      = 3;
  localparam int          DC_INPUT_BIT     = 4;
  localparam int          SAG_BIT          = 5;
  localparam int          NUM_SOURCES      = 6;
  localparam int          SOURCE_MAIN_BIT  = 6;
  localparam int          GLOBAL_EN_BIT    = 1;
  localparam int          DC_SWITCH_EN_BIT = 2;
  localparam int          MEAS_PENDING_BIT = 0;
  localparam logic [7:0]  ZERO_BYTE        = 8'h00;
  localparam logic [7:0]  BAT_THRESH_RST   = 8'h00;
  localparam logic [7:0]  SUPPLY_DELTA_RST = 8'h00;
  // DC-input switchover timeouts, in microseconds, one per field value
  localparam int          CLK_PERIOD_PS    = 4000;
  localparam int          DC_TMO0_US       = 1;
  localparam int          DC_TMO1_US       = 2;
  localparam int          DC_TMO2_US       = 4;
  localparam int          DC_TMO3_US       = 8;
  localparam int          TMO_W            = 12;
  localparam logic [11:0] DC_TMO0_CYC = 12'((DC_TMO0_US * 1000000) / CLK_PERIOD_PS);
  localparam logic [11:0] DC_TMO1_CYC = 12'((DC_TMO1_US * 1000000) / CLK_PERIOD_PS);
  localparam logic [11:0] DC_TMO2_CYC = 12'((DC_TMO2_US * 1000000) / CLK_PERIOD_PS);
  localparam logic [11:0] DC_TMO3_CYC = 12'((DC_TMO3_US * 1000000) / CLK_PERIOD_PS);
  localparam int          MEAS_PERIOD_DEF  = 1024;
endpackage

// ---- sag_cycle_detector.sv ----
`timescale 1ns/1ps
module sag_cycle_detector #(
  parameter int CNT_W = 8
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic             line_below_in,
  input  wire logic             line_cycle_in,
  input  wire logic [CNT_W-1:0] sag_cycle_count_in,
  output logic                  sag_event_out
);
  logic [CNT_W-1:0] below_cnt_r;
  logic             fired_r;

  // Consecutive line cycles spent below the sag threshold
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      below_cnt_r <= '0;
    end else if (!line_below_in) begin
      below_cnt_r <= '0;
    end else if (line_cycle_in && below_cnt_r != '1) begin
      below_cnt_r <= below_cnt_r + 1'b1;
    end
  end

  // One event per sag episode, rearmed when the line recovers
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fired_r       <= 1'b0;
      sag_event_out <= 1'b0;
    end else begin
      sag_event_out <= 1'b0;
      if (!line_below_in) begin
        fired_r <= 1'b0;
      end else if (!fired_r && below_cnt_r >= sag_cycle_count_in
                   && sag_cycle_count_in != '0) begin
        fired_r       <= 1'b1;
        sag_event_out <= 1'b1;
      end
    end
  end
endmodule

// ---- tb_power_supply_event_interrupts.sv ----
`timescale 1ns/1ps
module tb_power_supply_event_interrupts;
  logic       sys_clk_in           = 1'b0;
  logic       reset_in             = 1'b1;
  logic [7:0] addr_in              = 8'h00;
  logic [7:0] wr_data_in           = 8'h00;
  logic       wr_in                = 1'b0;
  logic       rd_in                = 1'b0;
  logic [7:0] rd_data_out;
  logic       supply_on_battery_in = 1'b0;
  logic       dc_input_low_in      = 1'b0;
  logic       line_below_in        = 1'b0;
  logic       line_cycle_in        = 1'b0;
  logic [7:0] sag_cycle_count_in   = 8'h03;
  logic [7:0] vsw_result_in        = 8'h00;
  logic       vsw_valid_in         = 1'b0;
  logic [7:0] battery_result_in    = 8'h00;
  logic       battery_valid_in     = 1'b0;
  logic       measure_start_out;
  logic       dc_switch_req_out;
  logic       power_monitor_interrupt_out;
  int         irq_count;
  int         err_total            = 0;
  int         compares             = 0;
  int         cyc                  = 0;
  logic [7:0] vsw_v                = 8'h00;
  logic [7:0] bat_v;
  logic [7:0] d;
  logic [7:0] en;
  logic       g;
  int         n;
  logic [7:0] rst_addr [10] = '{8'hD8, 8'hDF, 8'hEC, 8'hF3, 8'hF4,
                                8'hF5, 8'hF8, 8'hFA, 8'hA9, 8'hA0};

  power_supply_event_interrupts #(.MEAS_PERIOD_CYC(16), .SAG_CNT_W(8))
    u_power_supply_event_interrupts (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .supply_on_battery_in(supply_on_battery_in), .dc_input_low_in(dc_input_low_in),
    .line_below_in(line_below_in), .line_cycle_in(line_cycle_in),
    .sag_cycle_count_in(sag_cycle_count_in), .vsw_result_in(vsw_result_in),
    .vsw_valid_in(vsw_valid_in), .battery_result_in(battery_result_in),
    .battery_valid_in(battery_valid_in), .measure_start_out(measure_start_out),
    .dc_switch_req_out(dc_switch_req_out),
    .power_monitor_interrupt_out(power_monitor_interrupt_out));

  core_irq_model u_core_irq_model (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .irq_in(power_monitor_interrupt_out), .irq_count_out(irq_count));

  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Long enough for every scenario with margin; a hang lands here
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] v);
    compares++;
    if (v !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, v);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic v);
    compares++;
    if (v !== e) begin
      err_total++;
      $display("unexpected %s exp %b got %b", nm, e, v);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    addr_in    <= a;
    wr_data_in <= v;
    wr_in      <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 v = rd_data_out;
  endtask

  function automatic logic exp_irq(input logic gl, input logic [7:0] e, input int k);
    return gl & e[k];
  endfunction

  function automatic int exp_dc(input logic [1:0] f);
    case (f)
      2'h0: return int'(psu_irq_pkg::DC_TMO0_CYC);
      2'h1: return int'(psu_irq_pkg::DC_TMO1_CYC);
      2'h2: return int'(psu_irq_pkg::DC_TMO2_CYC);
      default: return int'(psu_irq_pkg::DC_TMO3_CYC);
    endcase
  endfunction

  task automatic fire(input int k);
    @(posedge sys_clk_in);
    case (k)
      0: begin
        vsw_v = vsw_v ^ 8'h20;
        vsw_result_in <= vsw_v;
        vsw_valid_in  <= 1'b1;
        @(posedge sys_clk_in);
        vsw_valid_in <= 1'b0;
      end
      1: begin
        battery_result_in <= bat_v;
        battery_valid_in  <= 1'b1;
        @(posedge sys_clk_in);
        battery_valid_in <= 1'b0;
      end
      2: supply_on_battery_in <= 1'b1;
      3: supply_on_battery_in <= 1'b0;
      4: begin
        dc_input_low_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        dc_input_low_in <= 1'b0;
      end
      default: begin
        line_below_in <= 1'b1;
        repeat (sag_cycle_count_in) begin
          @(posedge sys_clk_in);
          line_cycle_in <= 1'b1;
          @(posedge sys_clk_in);
          line_cycle_in <= 1'b0;
        end
        @(posedge sys_clk_in);
        line_below_in <= 1'b0;
      end
    endcase
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask

  initial begin
    void'($urandom(20));
    repeat (6) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    foreach (rst_addr[i]) begin
      rd(rst_addr[i], d);
      chk8("reset_value", (rst_addr[i] == 8'hF4) ? 8'h40 : 8'h00, d);
    end
    chk1("irq_after_reset", 1'b0, power_monitor_interrupt_out);
    for (int i = 0; i < 2; i++) begin
      en = 8'($urandom);
      wr(i ? 8'hFA : 8'hF3, en);
      rd(i ? 8'hFA : 8'hF3, d);
      chk8("rw_readback", en, d);
    end
    wr(8'hDF, 8'hFF);
    rd(8'hDF, d);
    chk8("result_ro", 8'h00, d);
    wr(8'hA0, 8'hFF);
    rd(8'hA0, d);
    chk8("unmapped", 8'h00, d);
    wr(8'hEC, 8'hFF);
    rd(8'hEC, d);
    chk8("enable_rsvd", 8'h3F, d);
    wr(8'hF3, 8'h10);
    // Enables off, on, random, and global enable off in the last pass
    for (int p = 0; p < 4; p++) begin
      en = (p == 0) ? 8'h00 : (p == 1) ? 8'h3F : 8'($urandom_range(0, 63));
      g  = (p != 3);
      bat_v = 8'($urandom);
      sag_cycle_count_in <= 8'($urandom_range(1, 4));
      wr(8'hEC, en);
      wr(8'hA9, {6'h00, g, 1'b0});
      for (int k = 0; k < 6; k++) begin
        fire(k);
        chk1("irq", exp_irq(g, en, k), power_monitor_interrupt_out);
        rd(8'hF8, d);
        chk8("flags", 8'(1 << k), d);
        if (k == 1) begin
          rd(8'hDF, d);
          chk8("battery_result", bat_v, d);
        end
        if (k == 2 || k == 3) begin
          rd(8'hF4, d);
          chk8("source_main", (k == 3) ? 8'h40 : 8'h00, d & 8'h40);
        end
        wr(8'hF8, ~8'(1 << k));
        rd(8'hF8, d);
        chk8("flags_cleared", 8'h00, d);
        chk1("irq_cleared", 1'b0, power_monitor_interrupt_out);
      end
    end
    // Events in the very cycle of a zero write survive it
    for (int s = 1; s >= 0; s--) begin
      @(posedge sys_clk_in);
      addr_in              <= 8'hF8;
      wr_data_in           <= 8'h00;
      wr_in                <= 1'b1;
      supply_on_battery_in <= 1'(s);
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
    end
    rd(8'hF8, d);
    chk8("set_beats_clear", 8'h08, d);
    wr(8'hF8, 8'h00);
    // Change smaller than the threshold must not flag
    @(posedge sys_clk_in);
    vsw_result_in <= vsw_v ^ 8'h05;
    vsw_valid_in  <= 1'b1;
    @(posedge sys_clk_in);
    vsw_valid_in <= 1'b0;
    rd(8'hF8, d);
    chk8("small_delta", 8'h00, d);
    vsw_result_in <= vsw_v;
    wr(8'hD8, 8'h5A);
    #1 chk1("meas_on_write", 1'b1, measure_start_out);
    rd(8'hD8, d);
    chk8("meas_pending", 8'h01, d & 8'h01);
    @(posedge sys_clk_in);
    vsw_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    vsw_valid_in <= 1'b0;
    rd(8'hD8, d);
    chk8("meas_done", 8'h00, d & 8'h01);
    n = 0;
    repeat (64) begin
      @(posedge sys_clk_in);
      #1 n += int'(measure_start_out);
    end
    chk1("meas_periodic", 1'b1, n >= 3 && n <= 5);
    for (int f = 0; f < 4; f++) begin
      wr(8'hF5, 8'h04 | 8'(f));
      @(posedge sys_clk_in);
      dc_input_low_in <= 1'b1;
      n = 0;
      while (dc_switch_req_out !== 1'b1 && n < 2100) begin
        @(posedge sys_clk_in);
        #1 n++;
      end
      chk1("dc_timeout", 1'b1, n >= exp_dc(2'(f)) - 2 && n <= exp_dc(2'(f)) + 3);
      @(posedge sys_clk_in);
      dc_input_low_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      #1 chk1("dc_req_drop", 1'b0, dc_switch_req_out);
    end
    wr(8'hF8, 8'h00);
    chk1("core_saw_irq", 1'b1, irq_count > 0);
    final_report();
  end
endmodule
